/* hw/ebi_consts.svh */
`ifndef EBI_CONSTS_SVH
`define EBI_CONSTS_SVH
`define EBI_ADDR_W 20
`define EBI_DATA_W 16
`define EBI_LANE_W 8
`define EBI_AREA_W 2
`define EBI_NUM_AREAS 4
`define EBI_BCLK_DIV 4
`define EBI_AREA_MSB 19
`define EBI_AREA_LSB 18
`define EBI_IDLE_HI 1'b1
`endif

/* hw/ebi_pkg.sv */
`default_nettype none
package ebi_pkg;
    typedef enum logic [6:0] {
        EBI_IDLE = 7'b000_0001,
        EBI_ADDR = 7'b000_0010,
        EBI_LAT = 7'b000_0100,
        EBI_STRB = 7'b000_1000,
        EBI_DONE = 7'b001_0000,
        EBI_HOLD = 7'b010_0000,
        EBI_REC = 7'b100_0000
    } ebi_state_e;
endpackage : ebi_pkg
`default_nettype wire

/* hw/ebi_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module ebi_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;
    // first stage feeds only the second stage
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            meta_r <= '1;
            sync_r <= '1;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end
    assign o_sync = sync_r;
endmodule : ebi_sync
`default_nettype wire

/* hw/ebi_top.sv */
// Function
// - width-select low gives 16-bit, high 8-bit
// - separate bus: upper lanes only when 16-bit
// - drive twenty address lines during access
// - 8-bit multiplexed: address 0-7 then data
// - 16-bit multiplexed: address 1-8 then data
// - one of four active-low area selects per access
// - byte-lane strobes: even low, odd high on a 16-bit bus
// - read strobe low when reading
// - one pin (i_single_strobe) switches between strobe styles
// - high-byte enable low on odd address
// - address-latch strobe captures address
// - hold request low enters hold state
// - hold acknowledge low while in hold
// - wait request low stretches access
// - internal bus clock driven out
`timescale 1ns/1ps
`default_nettype none
`include "ebi_consts.svh"
module ebi_top
    import ebi_pkg::*;
#(
    parameter int ADDR_W = `EBI_ADDR_W,
    parameter int DATA_W = `EBI_DATA_W,
    parameter int BCLK_DIV = `EBI_BCLK_DIV
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_req,
    input wire logic i_write,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_word,
    input wire logic i_muxed,
    input wire logic i_single_strobe,
    output logic o_ack,
    output logic [DATA_W-1:0] o_rdata,
    input wire logic i_byte_sel,
    input wire logic i_hold_req_n,
    input wire logic i_wait_req_n,
    output logic o_bus_clk,
    output logic [ADDR_W-1:0] o_ext_address_lines,
    input wire logic [DATA_W-1:0] i_ext_data_lines,
    output logic [DATA_W-1:0] o_ext_data_lines,
    output logic [DATA_W-1:0] o_ext_data_lines_oe,
    output logic [`EBI_NUM_AREAS-1:0] o_area_select_n,
    output logic o_low_lane_write_strobe_n,
    output logic o_high_lane_write_strobe_n,
    output logic o_read_strobe_n,
    output logic o_addr_latch,
    output logic o_hold_acknowledge_n,
    output logic o_busy
);
    localparam int LW = `EBI_LANE_W;

    // ==========================================================
    // pin synchronisers
    // ==========================================================
    logic byte_s;
    logic hold_n_s;
    logic wait_n_s;
    logic [DATA_W-1:0] din_s;
    ebi_sync #(.WIDTH(3)) u_ctl_sync (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_async({i_byte_sel, i_hold_req_n, i_wait_req_n}),
        .o_sync({byte_s, hold_n_s, wait_n_s})
    );
    ebi_sync #(.WIDTH(DATA_W)) u_dat_sync (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_async(i_ext_data_lines),
        .o_sync(din_s)
    );

    // ==========================================================
    // bus clock divider
    // ==========================================================
    logic [7:0] div_r, div_nxt;
    logic bclk_r, bclk_nxt;
    logic tick;
    always_comb begin
        tick = (div_r == 8'(BCLK_DIV - 1));
        div_nxt = tick ? 8'h00 : div_r + 8'h01;
        bclk_nxt = bclk_r;
        if (tick) begin
            bclk_nxt = ~bclk_r;
        end
    end
    // bus steps advance on the bus clock rising edge only
    logic step;
    assign step = tick && !bclk_r;

    // ==========================================================
    // helper functions
    // ==========================================================
    function automatic logic [`EBI_NUM_AREAS-1:0] area_dec(
        input logic [ADDR_W-1:0] a
    );
        logic [`EBI_NUM_AREAS-1:0] d;
        d = '1;
        d[a[`EBI_AREA_MSB:`EBI_AREA_LSB]] = 1'b0;
        return d;
    endfunction : area_dec

    function automatic logic [LW-1:0] mux_addr(
        input logic [ADDR_W-1:0] a,
        input logic wide
    );
        return wide ? a[LW:1] : a[LW-1:0];
    endfunction : mux_addr

    // ==========================================================
    // access sequencer
    // ==========================================================
    ebi_state_e st_r, st_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] wdat_r, wdat_nxt;
    logic [DATA_W-1:0] rdat_r, rdat_nxt;
    logic wr_r, wr_nxt;
    logic word_r, word_nxt;
    logic mux_r, mux_nxt;
    logic sgl_r, sgl_nxt;
    logic wide_r, wide_nxt;
    logic ack_r, ack_nxt;
    logic [ADDR_W-1:0] ao_r, ao_nxt;
    logic [DATA_W-1:0] do_r, do_nxt;
    logic [DATA_W-1:0] oe_r, oe_nxt;
    logic [`EBI_NUM_AREAS-1:0] cs_r, cs_nxt;
    logic wrl_r, wrl_nxt;
    logic wrh_r, wrh_nxt;
    logic rd_r, rd_nxt;
    logic ale_r, ale_nxt;
    logic hold_acknowledge_r, hold_acknowledge_nxt;
    logic busy_r, busy_nxt;

    always_comb begin
        st_nxt = st_r;
        addr_nxt = addr_r;
        wdat_nxt = wdat_r;
        rdat_nxt = rdat_r;
        wr_nxt = wr_r;
        word_nxt = word_r;
        mux_nxt = mux_r;
        sgl_nxt = sgl_r;
        wide_nxt = wide_r;
        ack_nxt = 1'b0;
        ao_nxt = ao_r;
        do_nxt = do_r;
        oe_nxt = oe_r;
        cs_nxt = cs_r;
        wrl_nxt = wrl_r;
        wrh_nxt = wrh_r;
        rd_nxt = rd_r;
        ale_nxt = ale_r;
        hold_acknowledge_nxt = hold_acknowledge_r;
        busy_nxt = busy_r;
        if (step) begin
            case (st_r)
                EBI_IDLE: begin
                    if (!hold_n_s) begin
                        st_nxt = EBI_HOLD;
                        hold_acknowledge_nxt = 1'b0;
                        busy_nxt = 1'b1;
                    end else if (i_req) begin
                        addr_nxt = i_addr;
                        wdat_nxt = i_wdata;
                        wr_nxt = i_write;
                        mux_nxt = i_muxed;
                        sgl_nxt = i_single_strobe;
                        wide_nxt = !byte_s;
                        // a word on an 8-bit bus degrades to one byte
                        word_nxt = i_word && !byte_s;
                        busy_nxt = 1'b1;
                        st_nxt = EBI_ADDR;
                    end
                end
                EBI_ADDR: begin
                    ao_nxt = addr_r;
                    cs_nxt = area_dec(addr_r);
                    ale_nxt = 1'b1;
                    oe_nxt = '0;
                    if (mux_r) begin
                        do_nxt[LW-1:0] = mux_addr(addr_r, wide_r);
                        oe_nxt[LW-1:0] = '1;
                    end
                    st_nxt = EBI_LAT;
                end
                EBI_LAT: begin
                    ale_nxt = 1'b0;
                    oe_nxt = '0;
                    if (wr_r) begin
                        do_nxt = wdat_r;
                        // odd bytes travel on the upper lane of a wide bus
                        if (wide_r && addr_r[0] && !word_r) begin
                            do_nxt[DATA_W-1:LW] = wdat_r[LW-1:0];
                        end
                        oe_nxt[LW-1:0] = '1;
                        if (wide_r && !mux_r) begin
                            oe_nxt[DATA_W-1:LW] = '1;
                        end
                        if (sgl_r) begin
                            wrl_nxt = 1'b0;
                        end else begin
                            wrl_nxt = !(word_r || !addr_r[0] || !wide_r);
                            wrh_nxt = !(word_r || (addr_r[0] && wide_r));
                        end
                    end else begin
                        rd_nxt = 1'b0;
                    end
                    if (sgl_r) begin
                        wrh_nxt = !(addr_r[0] || word_r);
                    end
                    st_nxt = EBI_STRB;
                end
                EBI_STRB: begin
                    // strobes, address and select stand while wait is low
                    if (wait_n_s) begin
                        if (!wr_r) begin
                            rdat_nxt = din_s;
                            if (wide_r && addr_r[0] && !word_r) begin
                                rdat_nxt = {{LW{1'b0}}, din_s[DATA_W-1:LW]};
                            end else if (!word_r || !wide_r || mux_r) begin
                                rdat_nxt[DATA_W-1:LW] = '0;
                            end
                        end
                        wrl_nxt = `EBI_IDLE_HI;
                        wrh_nxt = `EBI_IDLE_HI;
                        rd_nxt = `EBI_IDLE_HI;
                        st_nxt = EBI_DONE;
                    end
                end
                EBI_DONE: begin
                    cs_nxt = '1;
                    oe_nxt = '0;
                    ack_nxt = 1'b1;
                    st_nxt = EBI_REC;
                end
                EBI_REC: begin
                    busy_nxt = 1'b0;
                    st_nxt = EBI_IDLE;
                end
                EBI_HOLD: begin
                    // bus released: data line drivers off while held, address lines still driven
                    oe_nxt = '0;
                    if (hold_n_s) begin
                        hold_acknowledge_nxt = 1'b1;
                        busy_nxt = 1'b0;
                        st_nxt = EBI_IDLE;
                    end
                end
                default: begin
                    st_nxt = EBI_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            div_r <= 8'h00;
            bclk_r <= 1'b0;
            st_r <= EBI_IDLE;
            addr_r <= '0;
            wdat_r <= '0;
            rdat_r <= '0;
            wr_r <= 1'b0;
            word_r <= 1'b0;
            mux_r <= 1'b0;
            sgl_r <= 1'b0;
            wide_r <= 1'b0;
            ack_r <= 1'b0;
            ao_r <= '0;
            do_r <= '0;
            oe_r <= '0;
            cs_r <= '1;
            wrl_r <= 1'b1;
            wrh_r <= 1'b1;
            rd_r <= 1'b1;
            ale_r <= 1'b0;
            hold_acknowledge_r <= 1'b1;
            busy_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            bclk_r <= bclk_nxt;
            st_r <= st_nxt;
            addr_r <= addr_nxt;
            wdat_r <= wdat_nxt;
            rdat_r <= rdat_nxt;
            wr_r <= wr_nxt;
            word_r <= word_nxt;
            mux_r <= mux_nxt;
            sgl_r <= sgl_nxt;
            wide_r <= wide_nxt;
            ack_r <= ack_nxt;
            ao_r <= ao_nxt;
            do_r <= do_nxt;
            oe_r <= oe_nxt;
            cs_r <= cs_nxt;
            wrl_r <= wrl_nxt;
            wrh_r <= wrh_nxt;
            rd_r <= rd_nxt;
            ale_r <= ale_nxt;
            hold_acknowledge_r <= hold_acknowledge_nxt;
            busy_r <= busy_nxt;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    assign o_bus_clk = bclk_r;
    assign o_ack = ack_r;
    assign o_rdata = rdat_r;
    assign o_ext_address_lines = ao_r;
    assign o_ext_data_lines = do_r;
    assign o_ext_data_lines_oe = oe_r;
    assign o_area_select_n = cs_r;
    assign o_low_lane_write_strobe_n = wrl_r;
    assign o_high_lane_write_strobe_n = wrh_r;
    assign o_read_strobe_n = rd_r;
    assign o_addr_latch = ale_r;
    assign o_hold_acknowledge_n = hold_acknowledge_r;
    assign o_busy = busy_r;
endmodule : ebi_top
`default_nettype wire

/* testbench/ebi_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ====================
// external bus checker
module ebi_chk (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_muxed,
    input wire logic i_single_strobe,
    input wire logic i_byte_sel,
    input wire logic o_bus_clk,
    input wire logic [19:0] o_ext_address_lines,
    input wire logic [15:0] o_ext_data_lines,
    input wire logic [15:0] o_ext_data_lines_oe,
    input wire logic [3:0] o_area_select_n,
    input wire logic o_low_lane_write_strobe_n,
    input wire logic o_high_lane_write_strobe_n,
    input wire logic o_read_strobe_n,
    input wire logic o_addr_latch,
    input wire logic o_hold_acknowledge_n,
    input wire logic o_busy
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    sequence s_bclk_high;
        o_bus_clk[*4] ##1 !o_bus_clk;
    endsequence
    // address and select must not move while the strobe is out
    sequence s_rd_low;
        (!o_read_strobe_n && $stable(o_ext_address_lines)
            && $stable(o_area_select_n))[*8];
    endsequence
    AST_AREA: assert property (o_area_select_n != 4'hF |->
        o_area_select_n == ~(4'h1 << o_ext_address_lines[19:18]))
        else $error("area select does not match address");
    AST_HOLD: assert property (!o_hold_acknowledge_n |-> o_busy
        && o_ext_data_lines_oe == 16'h0000 && o_area_select_n == 4'hF)
        else $error("bus not released in hold");
    AST_MUX: assert property (o_addr_latch && i_muxed |->
        o_ext_data_lines[7:0] == (i_byte_sel ? o_ext_address_lines[7:0]
        : o_ext_address_lines[8:1])) else $error("mux address phase wrong");
    AST_RD_WR: assert property (!o_read_strobe_n |->
        o_low_lane_write_strobe_n) else $error("read and write together");
    AST_BHE: assert property (i_single_strobe && !o_read_strobe_n
        && o_ext_address_lines[0] |-> !o_high_lane_write_strobe_n)
        else $error("byte enable high on odd access");
    AST_LANES8: assert property (i_byte_sel |->
        o_ext_data_lines_oe[15:8] == 8'h00)
        else $error("upper lanes driven on narrow bus");
    AST_BCLK: assert property ($rose(o_bus_clk) |-> s_bclk_high)
        else $error("bus clock period wrong");
    AST_STRB: assert property ($fell(o_read_strobe_n) |-> s_rd_low)
        else $error("strobe phase too short or unstable");
endmodule : ebi_chk

bind ebi_top ebi_chk u_chk (
    .i_sys_clk, .i_reset, .i_muxed, .i_single_strobe, .i_byte_sel,
    .o_bus_clk, .o_ext_address_lines, .o_ext_data_lines,
    .o_ext_data_lines_oe, .o_area_select_n, .o_low_lane_write_strobe_n,
    .o_high_lane_write_strobe_n, .o_read_strobe_n, .o_addr_latch,
    .o_hold_acknowledge_n, .o_busy
);
`default_nettype wire

/* testbench/ebi_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================
// external memory on the bus
module ebi_mem_model (
    input wire logic i_sys_clk,
    input wire logic i_byte_sel,
    input wire logic i_single,
    input wire logic i_slow,
    input wire logic [19:0] i_addr,
    input wire logic [15:0] i_data,
    input wire logic i_wl_n,
    input wire logic i_wh_n,
    input wire logic i_rd_n,
    output logic [15:0] o_data,
    output logic o_wait_n
);
    logic [7:0] mem [256];
    logic [7:0] ev;
    logic [7:0] od;
    logic wl_q = 1'b1;
    logic wh_q = 1'b1;
    logic rd_q = 1'b1;
    int cnt = 40;
    assign ev = {i_addr[7:1], 1'b0};
    assign od = {i_addr[7:1], 1'b1};
    // slow mode pulls wait low for 20 cycles of a read strobe
    assign o_wait_n = !(i_slow && !i_rd_n && cnt < 20);
    initial o_data = 16'h0000;
    always @(posedge i_sys_clk) begin
        wl_q <= i_wl_n;
        wh_q <= i_wh_n;
        rd_q <= i_rd_n;
        cnt <= (!i_rd_n && rd_q) ? 0 : (cnt < 40 ? cnt + 1 : cnt);
        // data taken as the strobe rises
        if (i_wl_n && !wl_q)
            mem[(i_single && i_byte_sel) ? i_addr[7:0] : ev] <= i_data[7:0];
        if (i_wh_n && !wh_q && !i_single)
            mem[od] <= i_data[15:8];
        // released lanes toggle so stale data never looks valid
        if (!i_rd_n)
            o_data <= i_byte_sel ? {~o_data[15:8], mem[i_addr[7:0]]}
                : {mem[od], mem[ev]};
        else
            o_data <= ~o_data;
    end
endmodule : ebi_mem_model
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// =================
// external bus test
module tb;
    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_req = 1'b0;
    logic i_write = 1'b0;
    logic i_word = 1'b0;
    logic i_muxed = 1'b0;
    logic i_single_strobe = 1'b0;
    logic i_byte_sel = 1'b0;
    logic i_hold_req_n = 1'b1;
    logic slow = 1'b0;
    logic [19:0] i_addr = 20'h0_0000;
    logic [15:0] i_wdata = 16'h0000;
    logic [15:0] i_ext_data_lines, o_ext_data_lines, o_ext_data_lines_oe;
    logic [15:0] o_rdata, mdl_data, rd_val;
    logic [19:0] o_ext_address_lines, adr_seen;
    logic [3:0] o_area_select_n, sel_seen;
    logic o_ack, o_bus_clk, o_low_lane_write_strobe_n, o_addr_latch;
    logic o_high_lane_write_strobe_n, o_read_strobe_n, o_hold_acknowledge_n;
    logic o_busy, wait_n;
    int errors = 0;
    int compares = 0;
    int lat;
    assign i_ext_data_lines = (o_ext_data_lines_oe & o_ext_data_lines)
        | (~o_ext_data_lines_oe & mdl_data);
    always #2.5 i_sys_clk = ~i_sys_clk;
    ebi_top DUT (
        .i_sys_clk, .i_reset, .i_req, .i_write, .i_addr, .i_wdata, .i_word,
        .i_muxed, .i_single_strobe, .o_ack, .o_rdata, .i_byte_sel,
        .i_hold_req_n, .i_wait_req_n(wait_n), .o_bus_clk,
        .o_ext_address_lines, .i_ext_data_lines, .o_ext_data_lines,
        .o_ext_data_lines_oe, .o_area_select_n, .o_low_lane_write_strobe_n,
        .o_high_lane_write_strobe_n, .o_read_strobe_n, .o_addr_latch,
        .o_hold_acknowledge_n, .o_busy
    );
    ebi_mem_model u_mem (
        .i_sys_clk, .i_byte_sel, .i_single(i_single_strobe), .i_slow(slow),
        .i_addr(o_ext_address_lines), .i_data(o_ext_data_lines),
        .i_wl_n(o_low_lane_write_strobe_n),
        .i_wh_n(o_high_lane_write_strobe_n), .i_rd_n(o_read_strobe_n),
        .o_data(mdl_data), .o_wait_n(wait_n)
    );
    task automatic cmp(input logic [19:0] exp, input logic [19:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : tick
    task automatic idle;
        int n;
        n = 0;
        while (o_busy !== 1'b0 && n < 200) begin
            tick(1);
            n++;
        end
    endtask : idle
    // pin syncs need a few edges before a request may rely on them
    task automatic cfg(input logic bs, input logic sg, input logic mx);
        idle();
        i_byte_sel = bs;
        i_single_strobe = sg;
        i_muxed = mx;
        tick(4);
    endtask : cfg
    task automatic access(input logic w, input logic [19:0] a,
                          input logic [15:0] d, input logic wd);
        idle();
        i_write = w;
        i_addr = a;
        i_wdata = d;
        i_word = wd;
        i_req = 1'b1;
        lat = 0;
        while (o_busy !== 1'b1 && lat < 200) begin
            tick(1);
            lat++;
        end
        i_req = 1'b0;
        lat = 0;
        sel_seen = 4'hF;
        adr_seen = 20'h0_0000;
        while (o_ack !== 1'b1 && lat < 200) begin
            tick(1);
            lat++;
            if (o_area_select_n != 4'hF) begin
                sel_seen = o_area_select_n;
                adr_seen = o_ext_address_lines;
            end
        end
        rd_val = o_rdata;
        cmp(20'h0_0001, {19'h0_0000, o_ack});
    endtask : access
    task automatic t_sep16;
        cfg(1'b0, 1'b0, 1'b0);
        access(1'b1, 20'h0_0010, 16'hA55A, 1'b1);
        access(1'b1, 20'h0_0013, 16'h003C, 1'b0);
        access(1'b0, 20'h0_0010, 16'h0000, 1'b1);
        cmp(20'h0_A55A, {4'h0, rd_val});
        access(1'b0, 20'h0_0013, 16'h0000, 1'b0);
        cmp(20'h0_003C, {12'h000, rd_val[7:0]});
        $display("test sep16 done");
    endtask : t_sep16
    task automatic t_bus8;
        cfg(1'b1, 1'b1, 1'b0);
        access(1'b1, 20'h0_0021, 16'h0077, 1'b0);
        access(1'b0, 20'h0_0021, 16'h0000, 1'b0);
        cmp(20'h0_0077, {12'h000, rd_val[7:0]});
        $display("test bus8 done");
    endtask : t_bus8
    task automatic t_mux;
        for (int b = 0; b < 2; b++) begin
            cfg(b[0], b[0], 1'b1);
            access(1'b1, {18'h0_0010, b[0], 1'b0}, {15'h0060, b[0]}, 1'b0);
            access(1'b0, {18'h0_0010, b[0], 1'b0}, 16'h0000, 1'b0);
            cmp({12'h000, 7'h60, b[0]}, {12'h000, rd_val[7:0]});
        end
        $display("test mux done");
    endtask : t_mux
    task automatic t_wait;
        cfg(1'b0, 1'b0, 1'b0);
        slow = 1'b1;
        access(1'b0, 20'h0_0010, 16'h0000, 1'b1);
        slow = 1'b0;
        cmp(20'h0_A55A, {4'h0, rd_val});
        cmp(20'h0_0001, {19'h0_0000, lat > 40});
        $display("test wait done");
    endtask : t_wait
    task automatic t_hold;
        idle();
        i_hold_req_n = 1'b0;
        tick(40);
        cmp(20'h0_0001, {18'h0_0000, o_hold_acknowledge_n, o_busy});
        i_hold_req_n = 1'b1;
        tick(40);
        cmp(20'h0_0002, {18'h0_0000, o_hold_acknowledge_n, o_busy});
        $display("test hold done");
    endtask : t_hold
    task automatic t_areas;
        for (int k = 0; k < 4; k++) begin
            access(1'b0, {k[1:0], 18'h0_0010}, 16'h0000, 1'b1);
            cmp({16'h0000, ~(4'h1 << k)}, {16'h0000, sel_seen});
            cmp({k[1:0], 18'h0_0010}, adr_seen);
        end
        $display("test areas done");
    endtask : t_areas
    task automatic wrap_up;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    initial begin
        #50000;
        errors++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge i_sys_clk);
        #1;
        i_reset = 1'b0;
        t_sep16();
        t_bus8();
        t_mux();
        t_wait();
        t_hold();
        t_areas();
        wrap_up();
    end
endmodule : tb
`default_nettype wire
